// >>> flash_cmd_pkg.sv
// Opcodes, field positions and framing constants for the command decode slice
package flash_cmd_pkg;

    // Identification and security opcodes
    localparam logic [7:0] OP_JEDEC_IDENT_READ = 8'h9F;
    localparam logic [7:0] OP_LEGACY_SIG_READ = 8'hAB;
    localparam logic [7:0] OP_MAKER_DEV_IDENT_READ = 8'h90;
    localparam logic [7:0] OP_OTP_WINDOW_ENTER = 8'hB1;
    localparam logic [7:0] OP_OTP_WINDOW_LEAVE = 8'hC1;
    localparam logic [7:0] OP_LOCK_REG_READ = 8'h2B;
    localparam logic [7:0] OP_LOCK_REG_WRITE = 8'h2F;

    // Reset and escape opcodes
    localparam logic [7:0] OP_IDLE_CMD = 8'h00;
    localparam logic [7:0] OP_SOFT_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_SOFT_RESET_FIRE = 8'h99;
    localparam logic [7:0] OP_ESCAPE_ALL_ONES = 8'hFF;
    localparam logic [7:0] OP_ESCAPE_ALT_A = 8'hAA;
    localparam logic [7:0] OP_ESCAPE_ALT_B = 8'h55;

    // Write latch commands
    localparam logic [7:0] OP_SET_WRITE_LATCH_CMD = 8'h06;
    localparam logic [7:0] OP_CLEAR_WRITE_LATCH_CMD = 8'h04;

    // Commands that need the write latch
    localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h38;
    localparam logic [7:0] OP_SMALL_AREA_WIPE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
    localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
    localparam logic [7:0] OP_STATUS_CFG_WRITE = 8'h01;

    // Serial framing
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
    localparam logic [2:0] OPCODE_BYTE = 3'h0;
    localparam logic [2:0] HDR_LAST_BYTE = 3'h3;

    // Identification sequence positions
    localparam logic [1:0] SEQ_FIRST = 2'h0;
    localparam logic [1:0] SEQ_SECOND = 2'h1;
    localparam logic [1:0] SEQ_THIRD = 2'h2;
    localparam int MAKER_ADDR_BIT = 0;

    // Security byte layout
    localparam int LOCK_FIELD_OTP = 0;
    localparam int LOCK_FIELD_LOCKDOWN = 1;
    localparam int OTP_AREA_BITS = 8192;

    // Synchroniser width used on each side
    localparam int SYNC_WIDTH = 3;

endpackage

// >>> bit_sync.sv
// Two-stage level synchroniser, one bit per lane
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // bit_sync

// >>> spi_rx_shifter.sv
// Serial input shifter: bit position and byte count within one select frame
`timescale 1ns/1ps
module spi_rx_shifter (
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic [7:0] shreg,
    output logic [2:0] bit_idx,
    output logic [2:0] byte_cnt
);
    wire byte_edge = (bit_idx == flash_cmd_pkg::BIT_LAST);
    wire cnt_room = (byte_cnt != flash_cmd_pkg::BYTE_CNT_MAX);

    // Select high holds the shifter cleared, so every frame starts at bit 0
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            shreg <= 8'h00;
            bit_idx <= 3'h0;
            byte_cnt <= 3'h0;
        end else begin
            shreg <= {shreg[6:0], spi_sdi};
            bit_idx <= bit_idx + 3'h1;
            if (byte_edge && cnt_room) begin
                byte_cnt <= byte_cnt + 3'h1;
            end
        end
    end
endmodule // spi_rx_shifter

// >>> serial_flash_id_reset_wel_decoder.sv
// Command decode for identification, secured window, lock-down, soft reset and write latch
// Operation
// - Identification opcode returns maker byte then two device bytes, no address or dummies.
// - Identification opcode is not decoded while a program or erase runs.
// - Select high after an identification read returns the decoder to standby.
// - Legacy signature read: opcode, three ignored bytes, then one device byte repeated.
// - Maker/device read: address 0 gives maker first, address 1 device first.
// - One opcode enters the secured window mode, another returns to the array.
// - Lock register write sets lock-down for good and clears the write latch.
// - Reset fires only when arm is directly followed by reset; others cancel arming.
// - Program, erase and status writes are refused while the write latch is clear.
// - Write latch sets only on a frame holding exactly the set opcode byte.
// - Clear-latch opcode in an exact one-byte frame clears the write latch.
// - Only the single serial input is sampled; upper data lines are ignored.
// - Write latch clears at power-up and while the reset pin is low.
// - Write latch clears on program, erase, status write, suspend or soft reset.
`timescale 1ns/1ps
module serial_flash_id_reset_wel_decoder #(
    parameter logic [7:0] MAKER_CODE = 8'hA5,      // Arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE = 8'h3C,   // Arbitrary value
    parameter logic [7:0] DENSITY_CODE = 8'h07,    // Arbitrary value
    parameter logic [7:0] LEGACY_SIG_CODE = 8'h07, // Arbitrary value
    parameter logic [7:0] MAKER_DEV_CODE = 8'h07   // Arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    input wire logic hw_rst_n,
    input wire logic busy,
    input wire logic op_done,
    input wire logic suspend,
    input wire logic perf_mode,
    input wire logic lock_nv_in,
    output logic spi_so,
    output logic spi_so_oe,
    output logic write_latch_bit,
    output logic otp_window,
    output logic lockdown,
    output logic lock_nv_set,
    output logic soft_reset_pulse,
    output logic wr_cmd_grant,
    output logic wr_cmd_refused,
    output logic perf_exit
);
    typedef enum logic [1:0] {
        LINK_OPCODE,
        LINK_HEADER,
        LINK_SHIFT_OUT,
        LINK_DISCARD
    } link_state_t;

    // ---------------- Link domain ----------------
    logic [7:0] shreg;
    logic [2:0] bit_idx;
    logic [2:0] byte_cnt;
    logic [2:0] link_sync_q;
    link_state_t link_state;
    link_state_t next_link_state;
    logic [7:0] cmd;
    logic [7:0] next_cmd;
    logic [7:0] out_byte;
    logic [7:0] next_out_byte;
    logic [2:0] out_bit;
    logic [2:0] next_out_bit;
    logic [1:0] seq;
    logic [1:0] next_seq;
    logic tx_on;
    logic next_tx_on;
    logic [7:0] frame_op;
    logic frame_single;
    logic frame_tog;
    logic frame_whole;

    spi_rx_shifter u_rx (
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .shreg(shreg),
        .bit_idx(bit_idx),
        .byte_cnt(byte_cnt)
    );

    // Levels from the system side; sclk only runs in frames, but eight opcode
    // edges are enough to settle both stages before any decision is taken
    bit_sync #(
        .W(flash_cmd_pkg::SYNC_WIDTH)
    ) u_link_sync (
        .clk(spi_sclk),
        .rst(1'b0),
        .d({busy, lockdown, otp_window}),
        .q(link_sync_q)
    );

    wire busy_l = link_sync_q[2];
    wire lock_l = link_sync_q[1];
    wire otp_l = link_sync_q[0];

    wire [7:0] full_byte = {shreg[6:0], spi_sdi};
    wire last_bit = (bit_idx == flash_cmd_pkg::BIT_LAST);
    wire first_done = last_bit && (byte_cnt == flash_cmd_pkg::OPCODE_BYTE);
    wire hdr_done = last_bit && (byte_cnt == flash_cmd_pkg::HDR_LAST_BYTE);
    wire frame_start = (bit_idx == flash_cmd_pkg::BIT_FIRST) &&
                       (byte_cnt == flash_cmd_pkg::OPCODE_BYTE);

    wire [7:0] lock_byte = (8'h01 << flash_cmd_pkg::LOCK_FIELD_LOCKDOWN) & {8{lock_l}} |
                           (8'h01 << flash_cmd_pkg::LOCK_FIELD_OTP) & {8{otp_l}};

    // Byte presented at a given sequence position of the current read
    function automatic logic [7:0] id_byte(input logic [7:0] c, input logic [1:0] s,
                                           input logic [7:0] lb);
        logic [7:0] r;
        r = 8'h00;
        case (c)
            flash_cmd_pkg::OP_JEDEC_IDENT_READ: begin
                if (s == flash_cmd_pkg::SEQ_FIRST) begin
                    r = MAKER_CODE;
                end else if (s == flash_cmd_pkg::SEQ_SECOND) begin
                    r = MEM_TYPE_CODE;
                end else begin
                    r = DENSITY_CODE;
                end
            end
            flash_cmd_pkg::OP_LEGACY_SIG_READ: begin
                r = LEGACY_SIG_CODE;
            end
            flash_cmd_pkg::OP_MAKER_DEV_IDENT_READ: begin
                r = (s == flash_cmd_pkg::SEQ_FIRST) ? MAKER_CODE : MAKER_DEV_CODE;
            end
            flash_cmd_pkg::OP_LOCK_REG_READ: begin
                r = lb;
            end
            default: begin
                r = 8'h00;
            end
        endcase
        return r;
    endfunction

    // Position that follows s once a byte has gone out
    function automatic logic [1:0] seq_after(input logic [7:0] c, input logic [1:0] s);
        logic [1:0] r;
        r = flash_cmd_pkg::SEQ_FIRST;
        if (c == flash_cmd_pkg::OP_JEDEC_IDENT_READ) begin
            r = (s == flash_cmd_pkg::SEQ_THIRD) ? flash_cmd_pkg::SEQ_FIRST : s + 2'h1;
        end else if (c == flash_cmd_pkg::OP_MAKER_DEV_IDENT_READ) begin
            r = (s == flash_cmd_pkg::SEQ_FIRST) ? flash_cmd_pkg::SEQ_SECOND :
                                                  flash_cmd_pkg::SEQ_FIRST;
        end
        return r;
    endfunction

    wire op_jedec = (full_byte == flash_cmd_pkg::OP_JEDEC_IDENT_READ);
    wire op_hdr = (full_byte == flash_cmd_pkg::OP_LEGACY_SIG_READ) ||
                  (full_byte == flash_cmd_pkg::OP_MAKER_DEV_IDENT_READ);
    wire op_lock_rd = (full_byte == flash_cmd_pkg::OP_LOCK_REG_READ);
    wire [1:0] hdr_seq = (cmd == flash_cmd_pkg::OP_MAKER_DEV_IDENT_READ) ?
                         {1'b0, full_byte[flash_cmd_pkg::MAKER_ADDR_BIT]} :
                         flash_cmd_pkg::SEQ_FIRST;

    always_comb begin
        logic go;
        logic [1:0] go_seq;
        logic [7:0] go_cmd;
        go = 1'b0;
        go_seq = flash_cmd_pkg::SEQ_FIRST;
        go_cmd = cmd;
        next_link_state = link_state;
        next_cmd = cmd;
        next_out_byte = out_byte;
        next_out_bit = out_bit;
        next_seq = seq;
        next_tx_on = tx_on;
        case (link_state)
            LINK_OPCODE: begin
                if (first_done) begin
                    next_cmd = full_byte;
                    go_cmd = full_byte;
                    if (op_jedec && !busy_l) begin
                        go = 1'b1;
                    end else if (op_hdr) begin
                        next_link_state = LINK_HEADER;
                    end else if (op_lock_rd) begin
                        go = 1'b1;
                    end else begin
                        // Unknown and non-reading opcodes, and identification while busy, are swallowed here
                        next_link_state = LINK_DISCARD;
                    end
                end
            end
            LINK_HEADER: begin
                if (hdr_done) begin
                    go = 1'b1;
                    go_seq = hdr_seq;
                end
            end
            LINK_SHIFT_OUT: begin
                if (out_bit == flash_cmd_pkg::BIT_FIRST) begin
                    next_out_bit = flash_cmd_pkg::BIT_LAST;
                    next_seq = seq_after(cmd, seq);
                    next_out_byte = id_byte(cmd, seq_after(cmd, seq), lock_byte);
                end else begin
                    next_out_bit = out_bit - 3'h1;
                end
            end
            default: begin
                next_link_state = LINK_DISCARD;
            end
        endcase
        if (go) begin
            next_link_state = LINK_SHIFT_OUT;
            next_tx_on = 1'b1;
            next_out_bit = flash_cmd_pkg::BIT_LAST;
            next_seq = go_seq;
            next_out_byte = id_byte(go_cmd, go_seq, lock_byte);
        end
    end

    // Select high returns the link to standby between frames
    always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            link_state <= LINK_OPCODE;
            cmd <= 8'h00;
            out_byte <= 8'h00;
            out_bit <= flash_cmd_pkg::BIT_LAST;
            seq <= flash_cmd_pkg::SEQ_FIRST;
            tx_on <= 1'b0;
        end else begin
            link_state <= next_link_state;
            cmd <= next_cmd;
            out_byte <= next_out_byte;
            out_bit <= next_out_bit;
            seq <= next_seq;
            tx_on <= next_tx_on;
        end
    end

    // Data change on the falling edge so the host samples on the rising one
    always_ff @(negedge spi_sclk or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so <= out_byte[out_bit];
            spi_so_oe <= tx_on;
        end
    end

    // Frame summary survives select rising; read by the system side only
    // after the synchronised select edge, when sclk has stopped
    always_ff @(posedge spi_sclk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_op <= 8'h00;
            frame_single <= 1'b0;
            frame_tog <= 1'b0;
            frame_whole <= 1'b0;
        end else begin
            if (first_done) begin
                frame_op <= full_byte;
            end
            // A frame too short for an opcode must not replay the previous one
            frame_whole <= first_done || (frame_whole && !frame_start);
            frame_single <= first_done;
            if (frame_start) begin
                frame_tog <= ~frame_tog;
            end
        end
    end

    // ---------------- System domain ----------------
    logic [2:0] sys_sync_q;
    logic cs_d;
    logic tog_seen;
    logic exec_stb;
    logic armed;

    bit_sync #(
        .W(flash_cmd_pkg::SYNC_WIDTH)
    ) u_sys_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({hw_rst_n, spi_cs_n, frame_tog}),
        .q(sys_sync_q)
    );

    wire hw_rst_n_s = sys_sync_q[2];
    wire cs_s = sys_sync_q[1];
    wire tog_s = sys_sync_q[0];
    wire cs_rise = cs_s && !cs_d;

    function automatic logic needs_latch(input logic [7:0] c);
        return (c == flash_cmd_pkg::OP_PAGE_WRITE) ||
               (c == flash_cmd_pkg::OP_QUAD_PAGE_WRITE) ||
               (c == flash_cmd_pkg::OP_SMALL_AREA_WIPE) ||
               (c == flash_cmd_pkg::OP_HALF_BLOCK_WIPE) ||
               (c == flash_cmd_pkg::OP_BLOCK_WIPE) ||
               (c == flash_cmd_pkg::OP_CHIP_WIPE_A) ||
               (c == flash_cmd_pkg::OP_CHIP_WIPE_B) ||
               (c == flash_cmd_pkg::OP_STATUS_CFG_WRITE);
    endfunction

    wire ex_frame = exec_stb && frame_whole;
    wire ex_single = exec_stb && frame_single;
    wire ex_set_wl = ex_single && (frame_op == flash_cmd_pkg::OP_SET_WRITE_LATCH_CMD);
    wire ex_clr_wl = ex_single && (frame_op == flash_cmd_pkg::OP_CLEAR_WRITE_LATCH_CMD);
    wire ex_lock_wr = ex_single && (frame_op == flash_cmd_pkg::OP_LOCK_REG_WRITE);
    wire ex_otp_in = ex_single && (frame_op == flash_cmd_pkg::OP_OTP_WINDOW_ENTER);
    wire ex_otp_out = ex_single && (frame_op == flash_cmd_pkg::OP_OTP_WINDOW_LEAVE);
    wire ex_arm = ex_single && (frame_op == flash_cmd_pkg::OP_SOFT_RESET_ARM);
    wire ex_fire = ex_single && (frame_op == flash_cmd_pkg::OP_SOFT_RESET_FIRE) && armed;
    wire ex_wr_class = ex_frame && needs_latch(frame_op);
    wire ex_escape = ex_frame && perf_mode &&
                     ((frame_op == flash_cmd_pkg::OP_ESCAPE_ALL_ONES) ||
                      (frame_op == flash_cmd_pkg::OP_IDLE_CMD) ||
                      (frame_op == flash_cmd_pkg::OP_ESCAPE_ALT_A) ||
                      (frame_op == flash_cmd_pkg::OP_ESCAPE_ALT_B));
    wire wl_clear = ex_clr_wl || ex_lock_wr || op_done || suspend || ex_fire;

    // The toggle is compared on the select edge; executing one cycle later lets the frame record settle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_d <= 1'b1;
            tog_seen <= 1'b0;
            exec_stb <= 1'b0;
        end else begin
            cs_d <= cs_s;
            exec_stb <= cs_rise && (tog_s != tog_seen);
            if (cs_rise) begin
                tog_seen <= tog_s;
            end
        end
    end

    // The set command wins over a simultaneous completion clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            write_latch_bit <= 1'b0;
        end else if (!hw_rst_n_s) begin
            write_latch_bit <= 1'b0;
        end else if (ex_set_wl) begin
            write_latch_bit <= 1'b1;
        end else if (wl_clear) begin
            write_latch_bit <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            if (exec_stb || !hw_rst_n_s) begin
                armed <= ex_arm && hw_rst_n_s;
            end
            soft_reset_pulse <= ex_fire;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            otp_window <= 1'b0;
        end else if (ex_otp_in) begin
            otp_window <= 1'b1;
        end else if (ex_otp_out || ex_fire) begin
            otp_window <= 1'b0;
        end
    end

    // No path ever clears lock-down except power-up; nonvolatile copy reloads it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lockdown <= 1'b0;
            lock_nv_set <= 1'b0;
        end else begin
            lockdown <= lockdown || ex_lock_wr || lock_nv_in;
            lock_nv_set <= ex_lock_wr && !lockdown;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_cmd_grant <= 1'b0;
            wr_cmd_refused <= 1'b0;
            perf_exit <= 1'b0;
        end else begin
            wr_cmd_grant <= ex_wr_class && write_latch_bit;
            wr_cmd_refused <= ex_wr_class && !write_latch_bit;
            perf_exit <= ex_escape;
        end
    end

endmodule // serial_flash_id_reset_wel_decoder

// >>> serial_flash_id_reset_wel_decoder_props.sv
// Port-level assertions for the command decode slice
`timescale 1ns/1ps
module serial_flash_id_reset_wel_decoder_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spi_cs_n,
    input wire logic hw_rst_n,
    input wire logic op_done,
    input wire logic suspend,
    input wire logic spi_so_oe,
    input wire logic write_latch_bit,
    input wire logic lockdown,
    input wire logic lock_nv_set,
    input wire logic soft_reset_pulse,
    input wire logic wr_cmd_grant,
    input wire logic wr_cmd_refused
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    chk_oe_deselect: assert property (spi_cs_n && $past(spi_cs_n) |-> !spi_so_oe)
        else $error("serial out driven while deselected");
    chk_pin_clears: assert property (!hw_rst_n [*4] |-> !write_latch_bit)
        else $error("latch set while reset pin low");
    chk_lock_sticky: assert property (lockdown |=> lockdown)
        else $error("lock-down bit dropped");
    chk_lock_wel: assert property (lock_nv_set |-> ##[0:2] (lockdown && !write_latch_bit))
        else $error("lock write left latch or lock-down wrong");
    chk_grant_wel: assert property (wr_cmd_grant |-> $past(write_latch_bit) && !wr_cmd_refused)
        else $error("grant without latch");
    chk_refuse_wel: assert property (wr_cmd_refused |-> !$past(write_latch_bit))
        else $error("refusal with latch set");
    chk_done_clears: assert property ((op_done || suspend) && spi_cs_n && $past(spi_cs_n, 8)
        |-> ##[1:3] !write_latch_bit)
        else $error("latch kept after completion or suspend");
    chk_soft_clears: assert property (soft_reset_pulse |=> !soft_reset_pulse ##[0:1] !write_latch_bit)
        else $error("soft reset pulse or latch wrong");
endmodule // serial_flash_id_reset_wel_decoder_props

bind serial_flash_id_reset_wel_decoder serial_flash_id_reset_wel_decoder_props u_props (
    .clk, .sys_rst, .spi_cs_n, .hw_rst_n, .op_done, .suspend, .spi_so_oe, .write_latch_bit,
    .lockdown, .lock_nv_set, .soft_reset_pulse, .wr_cmd_grant, .wr_cmd_refused);

// >>> spi_host_model.sv
// Behavioural host controller driving mode 0 frames on the link
`timescale 1ns/1ps
module spi_host_model (
    input wire logic spi_so,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_sdi
);
    // A real rising select at start clears the shifter and link state of the block; the frame record waits for sys_rst
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b0;
        spi_sdi = 1'b0;
        #1 spi_cs_n = 1'b1;
    end

    // Frame of nb bits sent MSB first, then nr bits read; select may rise mid-byte
    // Callers send only defined opcodes, or cut or overlong frames of them
    // Header bytes are sent whole as part of nb
    // Clock stands low between frames; idle data toggles so a stale level is never trusted
    task automatic frame(input int nb, input logic [31:0] tx, input int nr,
                         output logic [31:0] rx);
        rx = '0;
        spi_cs_n = 1'b0;
        #3;
        for (int i = 0; i < nb + nr; i++) begin
            spi_sdi = (i < nb) ? tx[nb - 1 - i] : ~spi_sdi;
            #3 spi_sclk = 1'b1;
            if (i >= nb) rx = {rx[30:0], spi_so};
            #3 spi_sclk = 1'b0;
        end
        #3 spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
        // Gap keeps the system side from merging frames
        #250;
    endtask
endmodule // spi_host_model

// >>> serial_flash_id_reset_wel_decoder_tb.sv
// Self-checking bench for the command decode slice
`timescale 1ns/1ps
module serial_flash_id_reset_wel_decoder_tb;
    localparam logic [7:0] MK = 8'h5A; // Arbitrary value
    localparam logic [7:0] TY = 8'hC3; // Arbitrary value
    localparam logic [7:0] DN = 8'h1E; // Arbitrary value
    localparam logic [7:0] SG = 8'h4B; // Arbitrary value
    localparam logic [7:0] DV = 8'h69; // Arbitrary value
    logic clk, sys_rst, hw_rst_n, busy, op_done, suspend, perf_mode, lock_nv_in;
    logic spi_sclk, spi_cs_n, spi_sdi, spi_so, spi_so_oe, write_latch_bit, otp_window, lockdown;
    logic lock_nv_set, soft_reset_pulse, wr_cmd_grant, wr_cmd_refused, perf_exit, oe_seen;
    logic [31:0] rx;
    logic [7:0] ops [8] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7, 8'h01};
    logic [7:0] esc [4] = '{8'hFF, 8'h00, 8'hAA, 8'h55};
    int err_count = 0, checks = 0, cycles = 0, n_grant = 0, n_ref = 0, n_rst = 0, n_exit = 0;
    int n_lock = 0;

    serial_flash_id_reset_wel_decoder #(.MAKER_CODE(MK), .MEM_TYPE_CODE(TY), .DENSITY_CODE(DN),
        .LEGACY_SIG_CODE(SG), .MAKER_DEV_CODE(DV)) u_dut (
        .clk, .sys_rst, .spi_sclk, .spi_cs_n, .spi_sdi, .hw_rst_n, .busy, .op_done, .suspend,
        .perf_mode, .lock_nv_in, .spi_so, .spi_so_oe, .write_latch_bit, .otp_window, .lockdown,
        .lock_nv_set, .soft_reset_pulse, .wr_cmd_grant, .wr_cmd_refused, .perf_exit);
    // Undriven serial out reads as the inverse of its last level
    spi_host_model u_host (.spi_so(spi_so_oe ? spi_so : !spi_so), .spi_sclk, .spi_cs_n,
        .spi_sdi);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pulses last one cycle, so they are counted rather than sampled later
    always @(posedge clk) begin
        cycles++;
        n_grant += int'(wr_cmd_grant === 1'b1);
        n_ref += int'(wr_cmd_refused === 1'b1);
        n_rst += int'(soft_reset_pulse === 1'b1);
        n_exit += int'(perf_exit === 1'b1);
        n_lock += int'(lock_nv_set === 1'b1);
        if (cycles == 20000) begin
            err_count++;
            results;
        end
    end
    always @(posedge spi_sclk) if (spi_so_oe === 1'b1) oe_seen = 1'b1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task send(input int nb, input logic [31:0] tx);
        u_host.frame(nb, tx, 0, rx);
        cyc(6);
    endtask
    task pulse(input logic sel);
        if (sel) suspend <= 1'b1;
        else op_done <= 1'b1;
        cyc(1);
        suspend <= 1'b0;
        op_done <= 1'b0;
        cyc(4);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task t_ident;
        u_host.frame(8, 32'h9F, 32, rx);
        chk(rx, {MK, TY, DN, MK});
        u_host.frame(8, 32'h9F, 5, rx);
        chk(rx, 32'(MK[7:3]));
        chk(spi_so_oe, 1'b0);
        cyc(1);
        busy <= 1'b1;
        cyc(4);
        oe_seen = 1'b0;
        u_host.frame(8, 32'h9F, 16, rx);
        chk(oe_seen, 1'b0);
        chk(rx, 32'hFFFF);
        cyc(1);
        busy <= 1'b0;
        cyc(4);
    endtask
    task t_sig;
        u_host.frame(32, 32'hAB12_3456, 16, rx);
        chk(rx, {16'h0, SG, SG});
        u_host.frame(32, 32'h90FF_FF00, 16, rx);
        chk(rx, {16'h0, MK, DV});
        u_host.frame(32, 32'h9000_0001, 24, rx);
        chk(rx, {8'h0, DV, MK, DV});
    endtask
    task t_otp;
        send(8, 32'hB1);
        chk(otp_window, 1'b1);
        u_host.frame(8, 32'h2B, 16, rx);
        chk(rx, 32'h0101);
        send(8, 32'hC1);
        chk(otp_window, 1'b0);
    endtask
    task t_wel;
        send(8, 32'h06);
        chk(write_latch_bit, 1'b1);
        send(8, 32'h04);
        chk(write_latch_bit, 1'b0);
        send(9, 32'h0C);
        chk(write_latch_bit, 1'b0);
        send(8, 32'h06);
        send(7, 32'h02);
        chk(write_latch_bit, 1'b1);
        for (int i = 0; i < 8; i++) begin
            send(8, 32'h06);
            send(32, {ops[i], 24'h0});
            chk(n_grant, i + 1);
            pulse(i[0]);
            chk(write_latch_bit, 1'b0);
            send(8, {24'h0, ops[i]});
            chk(n_ref, i + 1);
        end
        send(5, 32'h0);
        chk(n_ref, 8);
        send(8, 32'h06);
        hw_rst_n <= 1'b0;
        cyc(6);
        chk(write_latch_bit, 1'b0);
        hw_rst_n <= 1'b1;
        cyc(4);
    endtask
    task t_lock;
        send(8, 32'h06);
        send(8, 32'h2F);
        chk({lockdown, write_latch_bit}, 2'b10);
        send(8, 32'h2F);
        chk(n_lock, 1);
        u_host.frame(8, 32'h2B, 8, rx);
        chk(rx, 32'h02);
        cyc(1);
        sys_rst <= 1'b1;
        cyc(20);
        sys_rst <= 1'b0;
        cyc(4);
        chk(lockdown, 1'b0);
        lock_nv_in <= 1'b1;
        cyc(6);
        lock_nv_in <= 1'b0;
        cyc(2);
        chk(lockdown, 1'b1);
    endtask
    task t_reset;
        send(8, 32'h06);
        send(8, 32'h66);
        send(8, 32'h99);
        chk({n_rst[1:0], write_latch_bit}, 3'h2);
        send(8, 32'h66);
        send(8, 32'h00);
        send(8, 32'h99);
        chk(n_rst, 1);
    endtask
    task t_perf;
        perf_mode <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            send(8, {24'h0, esc[i]});
            chk(n_exit, i + 1);
        end
        perf_mode <= 1'b0;
        send(8, 32'hFF);
        chk(n_exit, 4);
    endtask

    initial begin
        sys_rst = 1'b0;
        hw_rst_n = 1'b1;
        busy = 1'b0;
        op_done = 1'b0;
        suspend = 1'b0;
        perf_mode = 1'b0;
        lock_nv_in = 1'b0;
        // A real rising edge, so the link-side frame record is cleared
        #1 sys_rst = 1'b1;
        cyc(20);
        sys_rst <= 1'b0;
        cyc(4);
        t_ident;
        t_sig;
        t_otp;
        t_wel;
        t_lock;
        t_reset;
        t_perf;
        results;
    end
endmodule // serial_flash_id_reset_wel_decoder_tb
